// File: design/ifr_top.sv
// interrupt enable/disable port and frame period register behind classic wishbone
//
// Summary of operation
// - a one written to the disable port clears that interrupt enable bit
// - zero bits written to the disable port leave enable bits unchanged
// - reading the disable port returns the current interrupt enable contents
// - disable port uses read code 05 and write code 85
// - a one at disable bit 31 clears the master gate; zero ignored
// - master gate reads set after hardware or software reset
// - disable bits 6,5,4 clear hub change, count wrap, fatal error enables
// - disable bits 3,2,0 clear resume, frame begin, overrun enables; bit 1 reserved
// - frame period register holds 14-bit bit-time period between frame starts
// - frame period register holds 15-bit largest packet budget
// - frame period register uses read code 0D and write code 8D
// - irq only while status bit, its enable and master gate are set
// - period field resets to 11999; host controller reset restores it
// - frame-left counter reloads period at zero, toggle copies period toggle
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`include "ifr_regs.svh"

module ifr_top
  import ifr_pkg::*;
#(
  parameter int ADR_W = 12,
  parameter int FP_W  = 14,
  parameter int LPB_W = 15
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic             wb_we_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             hub_change_evt_i,
  input  wire logic             frame_count_wrap_evt_i,
  input  wire logic             fatal_system_error_evt_i,
  input  wire logic             resume_evt_i,
  input  wire logic             sched_overrun_evt_i,
  input  wire logic             bit_tick_i,
  input  wire logic             run_i,
  output logic                  irq_o,
  output logic                  frame_begin_o,
  output logic      [LPB_W-1:0] largest_packet_bits_o
);

  // ==========================================================
  // helper functions

  // byte enables widened to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction : lane_mask

  // command code plus direction to decoded command
  function automatic ifr_cmd_t cmd_of(input logic [7:0] code,
                                      input logic       we);
    ifr_cmd_t c;
    c = IFR_NONE;
    if (we) begin
      unique case (code)
        `IFR_CMDS_WR: c = IFR_CMDS_W;
        `IFR_STAT_WR: c = IFR_STAT_W;
        `IFR_EN_WR:   c = IFR_EN_W;
        `IFR_DIS_WR:  c = IFR_DIS_W;
        `IFR_FP_WR:   c = IFR_FP_W;
        default:      c = IFR_NONE;
      endcase
    end else begin
      unique case (code)
        `IFR_STAT_RD: c = IFR_STAT_R;
        `IFR_EN_RD:   c = IFR_EN_R;
        `IFR_DIS_RD:  c = IFR_DIS_R;
        `IFR_FP_RD:   c = IFR_FP_R;
        `IFR_FL_RD:   c = IFR_FL_R;
        default:      c = IFR_NONE;
      endcase
    end
    return c;
  endfunction : cmd_of

  // ==========================================================
  // declarations

  ifr_bus_t          bus_r;
  ifr_bus_t          bus_nxt;
  ifr_cmd_t          cmd;
  logic              req;
  logic              commit;
  logic [31:0]       wbits;
  logic [31:0]       rd_nxt;
  logic [31:0]       en_r;
  logic [31:0]       stat_r;
  logic [31:0]       evt;
  logic [31:0]       stat_clr;
  logic              hc_reset_r;
  logic              irq_nxt;
  logic [FP_W-1:0]   period_r;
  logic [LPB_W-1:0]  budget_r;
  logic              toggle_r;
  logic [FP_W-1:0]   left_count;
  logic              left_toggle;
  logic              frame_wrap;
  logic [31:0]       lanes;
  logic [FP_W-1:0]   period_nxt;
  logic [LPB_W-1:0]  budget_nxt;

  // ==========================================================
  // wishbone slave

  // word index is the command code; upper address bits ignored
  assign req    = wb_cyc_i && wb_stb_i;
  assign cmd    = cmd_of(wb_adr_i[9:2], wb_we_i);
  assign lanes  = lane_mask(wb_sel_i);
  assign wbits  = wb_dat_i & lanes;

  // writes land on the edge where the master sees ack high
  // a request still held after its ack is answered again, so masters must drop stb
  assign commit = req && (bus_r == IFR_BUS_ANSWER);

  // two-phase answer: data prepared in idle, ack held one cycle
  always_comb begin
    bus_nxt = bus_r;
    unique case (bus_r)
      IFR_BUS_IDLE: begin
        if (req) begin
          bus_nxt = IFR_BUS_ANSWER;
        end
      end
      IFR_BUS_ANSWER: begin
        bus_nxt = IFR_BUS_IDLE;
      end
    endcase
  end

  // bus phase state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_r <= IFR_BUS_IDLE;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  // ack straight from a flop, dropped after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= (bus_nxt == IFR_BUS_ANSWER);
    end
  end

  // read data mux; unmapped codes read as zero
  // disable port is read unmasked; sel only qualifies writes
  always_comb begin
    rd_nxt = '0;
    unique case (cmd)
      IFR_STAT_R: rd_nxt = stat_r;
      IFR_EN_R:   rd_nxt = en_r;
      IFR_DIS_R:  rd_nxt = en_r;
      IFR_FP_R: begin
        rd_nxt[`IFR_TOG_BIT]               = toggle_r;
        rd_nxt[`IFR_LPB_MSB:`IFR_LPB_LSB]  = budget_r;
        rd_nxt[`IFR_FP_MSB:`IFR_FP_LSB]    = period_r;
      end
      IFR_FL_R: begin
        rd_nxt[`IFR_TOG_BIT]               = left_toggle;
        rd_nxt[`IFR_FP_MSB:`IFR_FP_LSB]    = left_count;
      end
      default:    rd_nxt = '0;
    endcase
  end

  // read data latched while ack is raised, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (req && bus_r == IFR_BUS_IDLE) begin
      wb_dat_o <= rd_nxt;
    end else begin
      wb_dat_o <= '0;
    end
  end

  // ==========================================================
  // host controller reset command

  // one-cycle self-clearing pulse, reads back as zero
  // budget and toggle survive it; the driver reloads a saved period itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hc_reset_r <= 1'b0;
    end else begin
      hc_reset_r <= commit && cmd == IFR_CMDS_W && wbits[`IFR_HCR_BIT];
    end
  end

  // ==========================================================
  // interrupt enable with set port and clear port

  // set port ors bits in, disable port clears them; reserved stay zero
  // both ports never commit together: one request per answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r <= `IFR_EN_RESET;
    end else if (hc_reset_r) begin
      en_r <= `IFR_EN_RESET;
    end else if (commit && cmd == IFR_EN_W) begin
      en_r <= en_r | (wbits & `IFR_EN_MASK);
    end else if (commit && cmd == IFR_DIS_W) begin
      // ones clear, zeros keep, bit 1 and 30..7 untouched
      en_r <= en_r & ~(wbits & `IFR_EN_MASK);
    end
  end

  // ==========================================================
  // sticky event status, write one to clear

  // events collected at their status positions
  always_comb begin
    evt                 = '0;
    evt[`IFR_SO_BIT]    = sched_overrun_evt_i;
    evt[`IFR_FBEG_BIT]  = frame_wrap;
    evt[`IFR_RD_BIT]    = resume_evt_i;
    evt[`IFR_FATAL_BIT] = fatal_system_error_evt_i;
    evt[`IFR_WRAP_BIT]  = frame_count_wrap_evt_i;
    evt[`IFR_HUB_BIT]   = hub_change_evt_i;
  end

  // clear port reaches only the event positions
  assign stat_clr = (commit && cmd == IFR_STAT_W) ? (wbits & `IFR_EVT_MASK) : '0;

  // a set arriving with its own clear wins, so no event is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= '0;
    end else if (hc_reset_r) begin
      stat_r <= evt;
    end else begin
      stat_r <= (stat_r & ~stat_clr) | evt;
    end
  end

  // ==========================================================
  // interrupt request

  // needs status, matching enable and the master gate together
  // bit 1 and the reserved range can never raise the request
  assign irq_nxt = en_r[`IFR_GATE_BIT] && |(stat_r & en_r & `IFR_EVT_MASK);

  // registered level; one cycle behind the status flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_nxt;
    end
  end

  // ==========================================================
  // frame period register

  // merge written byte lanes into the held fields; reserved 15..14 never stored
  always_comb begin
    period_nxt = (period_r & ~lanes[`IFR_FP_MSB:`IFR_FP_LSB]) | wbits[`IFR_FP_MSB:`IFR_FP_LSB];
    budget_nxt = (budget_r & ~lanes[`IFR_LPB_MSB:`IFR_LPB_LSB]) | wbits[`IFR_LPB_MSB:`IFR_LPB_LSB];
  end

  // period field, default restored by the controller reset command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_r <= `IFR_FP_DEFAULT;
    end else if (hc_reset_r) begin
      period_r <= `IFR_FP_DEFAULT;
    end else if (commit && cmd == IFR_FP_W) begin
      // rewritable at any time, so a driver may trim each frame
      period_r <= period_nxt;
    end
  end

  // packet budget and update toggle keep their values over the reset command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      budget_r <= `IFR_LPB_RESET;
      toggle_r <= 1'b0;
    end else if (commit && cmd == IFR_FP_W) begin
      budget_r <= budget_nxt;
      if (wb_sel_i[3]) begin
        toggle_r <= wbits[`IFR_TOG_BIT];
      end
    end
  end

  // budget exported to the scheduler
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      largest_packet_bits_o <= `IFR_LPB_RESET;
    end else begin
      largest_packet_bits_o <= budget_r;
    end
  end

  // ==========================================================
  // frame-left counter

  // ticks are ignored while not operational, so the count is held
  ifr_frame_left #(
    .W (FP_W)
  ) u_frame_left (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .run_i           (run_i),
    .bit_tick_i      (bit_tick_i),
    .period_i        (period_r),
    .period_toggle_i (toggle_r),
    .count_o         (left_count),
    .toggle_o        (left_toggle),
    .wrap_o          (frame_wrap)
  );

  // frame start strobe, one cycle, a cycle after the wrap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_begin_o <= 1'b0;
    end else begin
      frame_begin_o <= frame_wrap;
    end
  end

endmodule : ifr_top

// File: design/ifr_regs.svh
// register codes, field positions, masks and reset values of the irq/frame register slice
`ifndef IFR_REGS_SVH
`define IFR_REGS_SVH

// ==========================================================
// command codes (word index on the bus, byte address = 4 x code)
`define IFR_CMDS_RD     8'h02
`define IFR_CMDS_WR     8'h82
`define IFR_STAT_RD     8'h03
`define IFR_STAT_WR     8'h83
`define IFR_EN_RD       8'h04
`define IFR_EN_WR       8'h84
`define IFR_DIS_RD      8'h05
`define IFR_DIS_WR      8'h85
`define IFR_FP_RD       8'h0d
`define IFR_FP_WR       8'h8d
`define IFR_FL_RD       8'h0e

// ==========================================================
// interrupt field positions
`define IFR_GATE_BIT    31
`define IFR_SO_BIT      0
`define IFR_FBEG_BIT    2
`define IFR_RD_BIT      3
`define IFR_FATAL_BIT   4
`define IFR_WRAP_BIT    5
`define IFR_HUB_BIT     6
`define IFR_EVT_MASK    32'h0000_007d
`define IFR_EN_MASK     32'h8000_007d
`define IFR_EN_RESET    32'h8000_0000
`define IFR_HCR_BIT     0

// ==========================================================
// frame period field positions and reset values
`define IFR_TOG_BIT     31
`define IFR_LPB_MSB     30
`define IFR_LPB_LSB     16
`define IFR_FP_MSB      13
`define IFR_FP_LSB      0
`define IFR_FP_MASK     32'hffff_3fff
`define IFR_FP_DEFAULT  14'h2edf
`define IFR_LPB_RESET   15'h0000

`endif

// File: design/ifr_pkg.sv
// types shared by the irq/frame register slice
package ifr_pkg;

  // ==========================================================
  // decoded bus command
  typedef enum logic [3:0] {
    IFR_NONE, IFR_CMDS_W, IFR_STAT_R, IFR_STAT_W, IFR_EN_R, IFR_EN_W,
    IFR_DIS_R, IFR_DIS_W, IFR_FP_R, IFR_FP_W, IFR_FL_R
  } ifr_cmd_t;

  // bus answer phase
  typedef enum logic {IFR_BUS_IDLE, IFR_BUS_ANSWER} ifr_bus_t;

endpackage : ifr_pkg

// File: design/ifr_frame_left.sv
// frame-left down-counter with toggle copy and frame wrap pulse
`timescale 1ns/1ps
`include "ifr_regs.svh"

module ifr_frame_left
  import ifr_pkg::*;
#(
  parameter int W = 14
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         run_i,
  input  wire logic         bit_tick_i,
  input  wire logic [W-1:0] period_i,
  input  wire logic         period_toggle_i,
  output logic      [W-1:0] count_o,
  output logic              toggle_o,
  output logic              wrap_o
);

  logic run_q_r;

  // run edge tracking, reload happens when operation starts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q_r <= 1'b0;
    end else begin
      run_q_r <= run_i;
    end
  end

  // count down once per bit time, reload at zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o  <= '0;
      toggle_o <= 1'b0;
      wrap_o   <= 1'b0;
    end else begin
      wrap_o <= 1'b0;
      if (run_i && !run_q_r) begin
        count_o <= period_i;
      end else if (run_i && bit_tick_i) begin
        if (count_o == '0) begin
          count_o  <= period_i;
          toggle_o <= period_toggle_i;
          wrap_o   <= 1'b1;
        end else begin
          count_o <= count_o - 1'b1;
        end
      end
    end
  end

endmodule : ifr_frame_left

// File: testbench/ifr_top_props.sv
// checker of bus, irq and frame pulse timing at the top ports
`timescale 1ns/1ps
module ifr_top_props
  import ifr_pkg::*;
#(
  parameter int ADR_W = 12,
  parameter int FP_W  = 14,
  parameter int LPB_W = 15
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic             wb_we_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             hub_change_evt_i,
  input wire logic             frame_count_wrap_evt_i,
  input wire logic             fatal_system_error_evt_i,
  input wire logic             resume_evt_i,
  input wire logic             sched_overrun_evt_i,
  input wire logic             bit_tick_i,
  input wire logic             run_i,
  input wire logic             irq_o,
  input wire logic             frame_begin_o,
  input wire logic [LPB_W-1:0] largest_packet_bits_o
);
  // ==========================================================
  // helpers and clocking
  logic [7:0] code;
  logic       any_evt;
  assign code    = wb_adr_i[9:2];
  assign any_evt = hub_change_evt_i | frame_count_wrap_evt_i | fatal_system_error_evt_i
                 | resume_evt_i | sched_overrun_evt_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // named steps
  sequence s_gate_off;
    wb_ack_o && wb_we_i && code == 8'h85 && wb_sel_i[3] && wb_dat_i[31];
  endsequence
  sequence s_budget_wr;
    wb_ack_o && wb_we_i && code == 8'h8d && wb_sel_i == 4'hf;
  endsequence

  // ==========================================================
  // properties
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_after_req: assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_zero_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_gate_kills_irq: assert property (s_gate_off |-> ##2 !irq_o [*3])
    else $error("irq survives gate clear");
  a_irq_has_cause: assert property ($rose(irq_o) |-> $past(any_evt, 2)
    || $past(wb_ack_o && wb_we_i, 2) || $past(frame_begin_o))
    else $error("irq rose without cause");
  a_frame_pulse_tick: assert property (frame_begin_o |->
    $past(bit_tick_i, 2) && $past(run_i, 2) ##1 !frame_begin_o)
    else $error("frame pulse without tick");
  a_budget_follows: assert property (s_budget_wr |->
    ##2 largest_packet_bits_o == $past(wb_dat_i[30:16], 2))
    else $error("budget output not updated");
endmodule : ifr_top_props

bind ifr_top ifr_top_props #(.ADR_W(ADR_W), .FP_W(FP_W), .LPB_W(LPB_W)) i_props (.*);

// File: testbench/ifr_host_model.sv
// host driver model: classic wishbone master issuing command codes
`timescale 1ns/1ps
module ifr_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  output logic      [11:0] adr_o,
  output logic      [31:0] dat_o,
  output logic      [3:0]  sel_o,
  output logic             we_o,
  output logic             cyc_o,
  output logic             stb_o
);
  // ==========================================================
  // idle bus at time zero
  initial begin
    adr_o = 12'h000;
    dat_o = 32'h0000_0000;
    sel_o = 4'hf;
    we_o  = 1'b0;
    cyc_o = 1'b0;
    stb_o = 1'b0;
  end

  // one request held until ack; released data shows the inverse
  task automatic xfer(input logic w, input logic [7:0] c, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    adr_o <= {2'b00, c, 2'b00};
    dat_o <= d;
    we_o  <= w;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = rdat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    dat_o <= ~d;
  endtask : xfer
endmodule : ifr_host_model

// File: testbench/test_ifr_top.sv
// self-checking bench for the irq disable port and frame period register
`timescale 1ns/1ps
`include "ifr_regs.svh"
module test_ifr_top;
  import ifr_pkg::*;
  logic        clk_i, rst_i, bit_tick_i, run_i, irq_o, frame_begin_o;
  logic        wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [11:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic [3:0]  wb_sel_i;
  logic [4:0]  ev;
  logic [14:0] lpb;
  int          fail_count, samples_checked;

  // ==========================================================
  // design, host model, clock
  ifr_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hub_change_evt_i(ev[4]),
    .frame_count_wrap_evt_i(ev[3]), .fatal_system_error_evt_i(ev[2]), .resume_evt_i(ev[1]),
    .sched_overrun_evt_i(ev[0]), .bit_tick_i(bit_tick_i), .run_i(run_i), .irq_o(irq_o),
    .frame_begin_o(frame_begin_o), .largest_packet_bits_o(lpb));
  ifr_host_model i_host (.clk_i(clk_i), .ack_i(wb_ack_o), .rdat_i(wb_dat_o), .adr_o(wb_adr_i),
    .dat_o(wb_dat_i), .sel_o(wb_sel_i), .we_o(wb_we_i), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] c, input logic [31:0] d);
    i_host.xfer(1'b1, c, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] c);
    i_host.xfer(1'b0, c, 32'h0000_0000, r);
  endtask : rd
  // single event cycle, then room for status and irq flops
  task automatic pulse(input logic [4:0] v);
    @(posedge clk_i) ev <= v;
    @(posedge clk_i) ev <= 5'h00;
    repeat (3) @(posedge clk_i);
  endtask : pulse
  task automatic tick;
    @(posedge clk_i) bit_tick_i <= 1'b1;
    @(posedge clk_i) bit_tick_i <= 1'b0;
  endtask : tick

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(`IFR_DIS_RD);
    chk(r, 32'h8000_0000);
    rd(`IFR_FP_RD);
    chk(r, 32'h0000_2edf);
    rd(`IFR_DIS_WR);
    chk(r, 32'h0000_0000);
    rd(8'h40);
    chk(r, 32'h0000_0000);
    $display("reset values done");
  endtask : t_reset
  task automatic t_disable;
    int          b[6] = '{0, 2, 3, 4, 5, 6};
    logic [31:0] e;
    wr(`IFR_EN_WR, 32'hffff_ffff);
    rd(`IFR_DIS_RD);
    chk(r, 32'h8000_007d);
    e = 32'h8000_007d;
    foreach (b[i]) begin
      wr(`IFR_DIS_WR, 32'h1 << b[i]);
      e[b[i]] = 1'b0;
      rd(`IFR_DIS_RD);
      chk(r, e);
    end
    wr(`IFR_DIS_WR, 32'h0000_0000);
    wr(`IFR_DIS_WR, 32'h8000_0000);
    rd(`IFR_EN_RD);
    chk(r, 32'h0000_0000);
    $display("disable port done");
  endtask : t_disable
  task automatic t_irq;
    int s[5] = '{6, 5, 4, 3, 0};
    wr(`IFR_EN_WR, 32'h8000_0079);
    foreach (s[i]) begin
      pulse(5'b10000 >> i);
      chk({31'h0, irq_o}, 32'h1);
      wr(`IFR_STAT_WR, 32'h1 << s[i]);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
    end
    wr(`IFR_DIS_WR, 32'h0000_0008);
    pulse(5'b00010);
    chk({31'h0, irq_o}, 32'h0);
    wr(`IFR_EN_WR, 32'h0000_0008);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(`IFR_DIS_WR, 32'h8000_0000);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(`IFR_STAT_WR, 32'h0000_0008);
    $display("interrupt gating done");
  endtask : t_irq
  task automatic t_frame;
    int n = 0;
    wr(`IFR_FP_WR, 32'h9234_c002);
    rd(`IFR_FP_RD);
    chk(r, 32'h9234_0002);
    chk({17'h0, lpb}, 32'h0000_1234);
    @(posedge clk_i) run_i <= 1'b1;
    repeat (2) tick();
    rd(`IFR_FL_RD);
    chk(r, 32'h0000_0000);
    tick();
    repeat (4) begin
      @(posedge clk_i);
      if (frame_begin_o === 1'b1) n++;
    end
    chk(n, 1);
    rd(`IFR_FL_RD);
    chk(r, 32'h8000_0002);
    rd(`IFR_STAT_RD);
    chk(r & 32'h4, 32'h4);
    wr(`IFR_FP_WR, 32'h1234_0001);
    repeat (3) tick();
    rd(`IFR_FL_RD);
    chk(r, 32'h0000_0001);
    @(posedge clk_i) run_i <= 1'b0;
    $display("frame counter done");
  endtask : t_frame
  task automatic t_swreset;
    wr(`IFR_CMDS_WR, 32'h0000_0001);
    rd(`IFR_FP_RD);
    chk(r, 32'h1234_2edf);
    rd(`IFR_DIS_RD);
    chk(r, 32'h8000_0000);
    $display("software reset done");
  endtask : t_swreset

  // ==========================================================
  // verdict, main sequence, watchdog
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  initial begin
    rst_i = 1'b1;
    bit_tick_i = 1'b0;
    run_i = 1'b0;
    ev = 5'h00;
    fail_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_disable();
    t_irq();
    t_frame();
    t_swreset();
    final_report();
  end
  // tests need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    final_report();
  end
endmodule : test_ifr_top
